/* hdl/perf_pkg.sv */
// holds the shared constants and types of the performance counter bank
// assumes every user sits on the cpu clock domain and refers by perf_pkg::name
package perf_pkg;

  // ********************************************
  // widths and counts
  // ********************************************
  localparam int CNT_W   = 32;   // width of one counter
  localparam int MAX_CH  = 4;    // channels that may run together
  localparam int SEL_W   = 5;    // width of one event selection code
  localparam int NUM_EVT = 20;   // codes in the event catalogue, disabled included
  localparam int PAD_W   = 32;   // event vector padded to every code of SEL_W bits

  // ********************************************
  // reset values and step sizes
  // ********************************************
  localparam logic [CNT_W-1:0] CNT_RESET   = 32'h0000_0000;
  localparam logic [1:0]       STEP_ONE    = 2'h1;
  localparam logic [1:0]       STEP_BRANCH = 2'h2;

  // ********************************************
  // event catalogue; the code is also the bit index in the cpu event vector
  // ********************************************
  typedef enum logic [4:0] {
    EV_DISABLED                      = 5'h00,
    EV_ELAPSED_CYCLE                 = 5'h01,
    branch_event                     = 5'h02,
    EV_CACHE_STALL                   = 5'h03,
    local_xy_mem_stall_event         = 5'h04,
    local_u_mem_stall_event          = 5'h05,
    noncache_access_cycle_event      = 5'h06,
    EV_NONCACHE_INSTR_CYCLE          = 5'h07,
    EV_NONCACHE_DATA_CYCLE           = 5'h08,
    cache_area_access_cycle_event    = 5'h09,
    EV_CACHE_INSTR_CYCLE             = 5'h0a,
    EV_CACHE_DATA_CYCLE              = 5'h0b,
    EV_OTHER_ACCESS_CYCLE            = 5'h0c,
    EV_NONCACHE_COUNT                = 5'h0d,
    EV_NONCACHE_INSTR_COUNT          = 5'h0e,
    EV_NONCACHE_DATA_COUNT           = 5'h0f,
    EV_CACHE_COUNT                   = 5'h10,
    EV_CACHE_INSTR_COUNT             = 5'h11,
    EV_CACHE_DATA_COUNT              = 5'h12,
    EV_OTHER_ACCESS_COUNT            = 5'h13
  } event_sel_t;

  // ********************************************
  // measurement range and controller states
  // ********************************************
  typedef enum logic [1:0] {
    MODE_NORMAL   = 2'b00,
    MODE_B1_TO_B2 = 2'b01,
    MODE_B2_TO_B1 = 2'b10
  } range_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ARMED = 2'b01,
    ST_COUNT = 2'b10,
    ST_DONE  = 2'b11
  } meas_state_t;

endpackage

/* hdl/perf_chan_if.sv */
// holds the bundle between the counter bank control and one counter channel
// assumes both ends run on the cpu clock
`timescale 1ns/1ns
interface perf_chan_if;
  perf_pkg::event_sel_t        sel;       // event code chosen for the channel
  logic                        hit;       // event seen while measuring, one cycle
  logic                        init;      // clear request, one cycle
  logic [perf_pkg::CNT_W-1:0]  count;     // accumulated value
  logic                        overflow;  // sticky wrap flag

  modport ctrl (output sel, output hit, output init, input count, input overflow);
  modport chan (input sel, input hit, input init, output count, output overflow);
endinterface

/* hdl/perf_channel.sv */
// holds one counter channel of the performance counter bank
// assumes hit already carries the measurement window and event presence
`timescale 1ns/1ns
module perf_channel
(
  input  wire logic  sys_clk,   // cpu clock, halts in sleep
  input  wire logic  rst_n,     // asynchronous reset, active low
  perf_chan_if.chan  port       // selection, hit and init in, count out
);

  // ********************************************
  // step and sum
  // ********************************************
  // branches step by two, every other event by one
  wire logic [1:0]                 step = (port.sel == perf_pkg::branch_event) ?
                                          perf_pkg::STEP_BRANCH : perf_pkg::STEP_ONE;
  wire logic [perf_pkg::CNT_W:0]   sum  = {1'b0, port.count} +
                                          {{(perf_pkg::CNT_W-1){1'b0}}, step};
  // an init in the same cycle drops the hit, so it cannot raise the flag either
  wire logic                       wrap = port.hit & ~port.init & sum[perf_pkg::CNT_W];

  // ********************************************
  // counter and sticky overflow
  // ********************************************
  // init wins over a hit: a cleared counter cannot wrap in the same cycle
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      port.count <= perf_pkg::CNT_RESET;
    else if (port.init)
      port.count <= perf_pkg::CNT_RESET;
    else if (port.hit)
      port.count <= sum[perf_pkg::CNT_W-1:0];
  end

  // flag stays up across the wrap so the host can reject the value
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      port.overflow <= 1'b0;
    else if (wrap)
      port.overflow <= 1'b1;
    else if (port.init)
      port.overflow <= 1'b0;
  end

  // ********************************************
  // checks
  // ********************************************
  property p_branch_step;
    @(posedge sys_clk) disable iff (!rst_n)
    port.hit && !port.init && port.sel == perf_pkg::branch_event
      |=> port.count - $past(port.count) == 32'h0000_0002;
  endproperty
  a_branch_step: assert property (p_branch_step) else $error("branch step not two");

  property p_plain_step;
    @(posedge sys_clk) disable iff (!rst_n)
    port.hit && !port.init && port.sel != perf_pkg::branch_event
      |=> port.count - $past(port.count) == 32'h0000_0001;
  endproperty
  a_plain_step: assert property (p_plain_step) else $error("event step not one");

  property p_init_clears;
    @(posedge sys_clk) disable iff (!rst_n)
    port.init |=> port.count == perf_pkg::CNT_RESET && !port.overflow;
  endproperty
  a_init_clears: assert property (p_init_clears) else $error("init left a value");

  property p_ovf_on_wrap;
    @(posedge sys_clk) disable iff (!rst_n)
    port.hit && !port.init && port.count == 32'hffff_ffff |=> port.overflow;
  endproperty
  a_ovf_on_wrap: assert property (p_ovf_on_wrap) else $error("wrap not flagged");

  property p_ovf_sticky;
    @(posedge sys_clk) disable iff (!rst_n)
    port.overflow && !port.init |=> port.overflow;
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow dropped");

endmodule

/* hdl/perf_counter_bank.sv */
// holds the performance counter bank of the on-chip debug unit
// assumes all inputs come from logic on the cpu clock, so none is synchronised;
// the debug port logic outside reads count_value and overflow
//
// How it works
// - each channel selects cycles or accesses split by area and instruction/data/other
// - stall events for cacheable, x/y and u memory; memory ones only if fitted
// - a taken branch advances the counter by two
// - with cache on, non-cacheable counts run low and cacheable ones high
// - counters run on the cpu clock and stop with it in sleep
// - counts taken in non-realtime trace mode are marked not trustworthy
// - each counter holds a 32-bit value the host reads out
// - a wrap during measurement is flagged so the result is reported invalid
// - an initialize request clears the accumulated values
// - up to four channels run together, each selected or disabled
// - count over the whole run, or from one break hit to the other
`timescale 1ns/1ns
module perf_counter_bank
#(
  parameter int NUM_CH      = 4,     // channels fitted
  parameter bit HAS_XY_MEM  = 1'b1,  // local x/y memory present
  parameter bit HAS_U_MEM   = 1'b1   // local u memory present
)
(
  input  wire logic                                    sys_clk,           // cpu clock
  input  wire logic                                    rst_n,             // async reset, low
  input  wire logic [NUM_CH*perf_pkg::SEL_W-1:0]       chan_sel,          // event code per channel
  input  wire logic [1:0]                              range_mode,        // measurement range
  input  wire logic                                    prog_run,          // user program running
  input  wire logic                                    brk_hit1,          // first comparator hit
  input  wire logic                                    brk_hit2,          // second comparator hit
  input  wire logic                                    init_req,          // clear counters, pulse
  input  wire logic                                    cache_on,          // caching enabled
  input  wire logic                                    trace_port_nonrt,  // trace non-realtime
  input  wire logic [perf_pkg::NUM_EVT-1:0]            cpu_event,         // event strobes by code
  output logic      [NUM_CH*perf_pkg::CNT_W-1:0]       count_value,       // counters, chan 0 low
  output logic      [NUM_CH-1:0]                       overflow,          // sticky wrap flags
  output logic                                         measuring,         // window is open
  output logic                                         result_suspect,    // counted in nonrt trace
  output logic                                         cache_skew         // area counts skewed
);

  // ********************************************
  // parameter checks
  // ********************************************
  // the bank serves one to four channels
  if (NUM_CH < 1 || NUM_CH > perf_pkg::MAX_CH)
  begin : g_bad_ch
    $error("NUM_CH must lie between 1 and 4");
  end

  // ********************************************
  // decoding functions
  // ********************************************
  // an event exists only if its source memory is fitted; disabled counts nothing
  function automatic logic evt_present(input perf_pkg::event_sel_t sel);
    logic ok;
    ok = 1'b1;
    if (sel == perf_pkg::EV_DISABLED)
      ok = 1'b0;
    else if (sel == perf_pkg::local_xy_mem_stall_event)
      ok = HAS_XY_MEM;
    else if (sel == perf_pkg::local_u_mem_stall_event)
      ok = HAS_U_MEM;
    else if (int'(sel) >= perf_pkg::NUM_EVT)
      ok = 1'b0;
    return ok;
  endfunction

  // area access events whose totals a running cache distorts
  function automatic logic area_event(input perf_pkg::event_sel_t sel);
    return sel >= perf_pkg::noncache_access_cycle_event &&
           sel <= perf_pkg::EV_OTHER_ACCESS_COUNT;
  endfunction

  // ********************************************
  // measurement window controller
  // ********************************************
  perf_pkg::meas_state_t  state;
  perf_pkg::meas_state_t  next_state;

  wire perf_pkg::range_mode_t mode      = perf_pkg::range_mode_t'(range_mode);
  wire logic                  by_break  = (mode != perf_pkg::MODE_NORMAL);
  // the two ranged modes swap the roles of the comparators
  wire logic                  start_hit = (mode == perf_pkg::MODE_B1_TO_B2) ? brk_hit1 : brk_hit2;
  wire logic                  end_hit   = (mode == perf_pkg::MODE_B1_TO_B2) ? brk_hit2 : brk_hit1;
  wire logic                  count_en  = (state == perf_pkg::ST_COUNT);

  // a stop of the program always closes the window, as a break ends the run
  always_comb
  begin
    next_state = state;
    case (state)
      perf_pkg::ST_IDLE:
        if (prog_run)
          next_state = by_break ? perf_pkg::ST_ARMED : perf_pkg::ST_COUNT;
      perf_pkg::ST_ARMED:
        if (!prog_run)
          next_state = perf_pkg::ST_IDLE;
        else if (start_hit)
          next_state = perf_pkg::ST_COUNT;
      perf_pkg::ST_COUNT:
        if (!prog_run || (by_break && end_hit))
          next_state = perf_pkg::ST_DONE;
      perf_pkg::ST_DONE:
        if (!prog_run)
          next_state = perf_pkg::ST_IDLE;
      default:
        next_state = perf_pkg::ST_IDLE;
    endcase
  end

  // every flop here is on sys_clk, so a halted cpu clock freezes the bank
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      state <= perf_pkg::ST_IDLE;
    else
      state <= next_state;
  end

  // registered copy so the output comes straight from a flop
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      measuring <= 1'b0;
    else
      measuring <= (next_state == perf_pkg::ST_COUNT);
  end

  // ********************************************
  // channels
  // ********************************************
  // padding lets every selection code index the vector safely
  wire logic [perf_pkg::PAD_W-1:0] evt_pad = {{(perf_pkg::PAD_W-perf_pkg::NUM_EVT){1'b0}},
                                              cpu_event};
  wire logic [NUM_CH-1:0]          skew_ch;

  perf_chan_if ch [NUM_CH] ();

  for (genvar i = 0; i < NUM_CH; i++)
  begin : g_ch
    wire perf_pkg::event_sel_t sel_i =
      perf_pkg::event_sel_t'(chan_sel[i*perf_pkg::SEL_W +: perf_pkg::SEL_W]);

    assign ch[i].sel  = sel_i;
    // event counted only inside the window and only if its source exists
    assign ch[i].hit  = count_en & evt_present(sel_i) & evt_pad[sel_i];
    assign ch[i].init = init_req;
    // with cache on, line fills inflate cacheable totals and hide uncached ones
    assign skew_ch[i] = area_event(sel_i);

    perf_channel u_chan
    (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .port    (ch[i])
    );

    assign count_value[i*perf_pkg::CNT_W +: perf_pkg::CNT_W] = ch[i].count;
    assign overflow[i] = ch[i].overflow;

    property p_absent_mem;
      @(posedge sys_clk) disable iff (!rst_n)
      (sel_i == perf_pkg::local_xy_mem_stall_event && !HAS_XY_MEM) ||
      (sel_i == perf_pkg::local_u_mem_stall_event && !HAS_U_MEM) ||
      sel_i == perf_pkg::EV_DISABLED
        |-> !ch[i].hit;
    endproperty
    a_absent_mem: assert property (p_absent_mem) else $error("missing event counted");

    property p_closed_window;
      @(posedge sys_clk) disable iff (!rst_n)
      !count_en && !init_req |=> ch[i].count == $past(ch[i].count);
    endproperty
    a_closed_window: assert property (p_closed_window) else $error("count moved idle");
  end

  // ********************************************
  // accuracy flags
  // ********************************************
  // both sticky until init; a new cause in the init cycle wins over the clear
  wire logic suspect_set = count_en & trace_port_nonrt;
  wire logic skew_set    = count_en & cache_on & (|skew_ch);

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      result_suspect <= 1'b0;
    else if (suspect_set)
      result_suspect <= 1'b1;
    else if (init_req)
      result_suspect <= 1'b0;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      cache_skew <= 1'b0;
    else if (skew_set)
      cache_skew <= 1'b1;
    else if (init_req)
      cache_skew <= 1'b0;
  end

  // ********************************************
  // window and accuracy flag checks
  // ********************************************
  sequence s_armed_start;
    state == perf_pkg::ST_ARMED && prog_run && start_hit;
  endsequence

  sequence s_open_two;
    measuring [*2];
  endsequence

  property p_range_open;
    @(posedge sys_clk) disable iff (!rst_n)
    s_armed_start ##1 (prog_run && !end_hit) |-> s_open_two;
  endproperty
  a_range_open: assert property (p_range_open) else $error("range did not open");

  property p_range_close;
    @(posedge sys_clk) disable iff (!rst_n)
    count_en && by_break && end_hit |=> !measuring ##1 !count_en;
  endproperty
  a_range_close: assert property (p_range_close) else $error("range did not close");

  property p_normal_whole_run;
    @(posedge sys_clk) disable iff (!rst_n)
    state == perf_pkg::ST_IDLE && !by_break && prog_run |=> measuring && count_en;
  endproperty
  a_normal_whole_run: assert property (p_normal_whole_run) else $error("run missed");

  property p_suspect_flag;
    @(posedge sys_clk) disable iff (!rst_n)
    count_en && trace_port_nonrt |=> result_suspect;
  endproperty
  a_suspect_flag: assert property (p_suspect_flag) else $error("nonrt trace not flagged");

  property p_skew_flag;
    @(posedge sys_clk) disable iff (!rst_n)
    skew_set |=> cache_skew;
  endproperty
  a_skew_flag: assert property (p_skew_flag) else $error("cache skew not flagged");

endmodule

/* verification/perf_counter_bank_bench.sv */
// self-checking bench for the performance counter bank, one task per scenario
// assumes hdl/perf_pkg.sv, the interface and both design modules are compiled first
`timescale 1ns/1ns
`define CHK(what, exp, got) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) \
    begin \
      error_cnt++; \
      $display("[FAIL] %s expected %h seen %h", what, exp, got); \
    end \
  end

module debug_performance_event_counters_bench;
  // ********************************************
  // stimulus and observed signals
  // ********************************************
  logic                            sys_clk;
  logic                            clk_run;
  logic                            rst_n;
  logic [19:0]                     chan_sel;
  logic [9:0]                      sel2;
  logic [1:0]                      range_mode;
  logic                            prog_run;
  logic                            brk_hit1;
  logic                            brk_hit2;
  logic                            init_req;
  logic                            cache_on;
  logic                            trace_port_nonrt;
  logic [perf_pkg::NUM_EVT-1:0]    cpu_event;
  logic [127:0]                    count_value;
  logic [63:0]                     count2;
  logic [3:0]                      overflow;
  logic                            measuring;
  logic                            result_suspect;
  logic                            cache_skew;
  int                              error_cnt;
  int                              num_checks;

  // full bank, all memories fitted
  perf_counter_bank dut_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .chan_sel(chan_sel), .range_mode(range_mode),
    .prog_run(prog_run), .brk_hit1(brk_hit1), .brk_hit2(brk_hit2), .init_req(init_req),
    .cache_on(cache_on), .trace_port_nonrt(trace_port_nonrt), .cpu_event(cpu_event),
    .count_value(count_value), .overflow(overflow), .measuring(measuring),
    .result_suspect(result_suspect), .cache_skew(cache_skew));

  // small bank without local memories, shares the stimulus of the first except chan_sel, which comes from sel2
  perf_counter_bank #(.NUM_CH(2), .HAS_XY_MEM(1'b0), .HAS_U_MEM(1'b0)) dut_u2 (
    .sys_clk(sys_clk), .rst_n(rst_n), .chan_sel(sel2), .range_mode(range_mode),
    .prog_run(prog_run), .brk_hit1(brk_hit1), .brk_hit2(brk_hit2), .init_req(init_req),
    .cache_on(cache_on), .trace_port_nonrt(trace_port_nonrt), .cpu_event(cpu_event),
    .count_value(count2), .overflow(), .measuring(), .result_suspect(), .cache_skew());

  // clock can be held to mimic the cpu clock halting in sleep
  always #20 if (clk_run) sys_clk = ~sys_clk;

  // ********************************************
  // helpers
  // ********************************************
  // inputs always move 2 ns after the rising edge, clear of the sampling point
  task automatic tick();
    @(posedge sys_clk);
    #2;
  endtask

  function automatic logic [31:0] cnt(int i);
    return count_value[32*i +: 32];
  endfunction

  task automatic pulse_init();
    init_req = 1'h1;
    tick();
    init_req = 1'h0;
    `CHK("counts after init", 128'h0, count_value)
    `CHK("overflow after init", 4'h0, overflow)
  endtask

  task automatic open_normal();
    range_mode = 2'h0;
    prog_run = 1'h1;
    tick();
    `CHK("window open", 1'h1, measuring)
  endtask

  task automatic close_window();
    prog_run = 1'h0;
    tick();
    `CHK("window closed", 1'h0, measuring)
    tick();
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ********************************************
  // scenarios
  // ********************************************
  task automatic t_reset();
    rst_n = 1'h0;
    repeat (4) tick();
    `CHK("counts in reset", 128'h0, count_value)
    `CHK("flags in reset", 3'h0, {measuring, result_suspect, cache_skew})
    rst_n = 1'h1;
    tick();
    $display("t_reset done");
  endtask

  // every code but the disabled one on some channel; bit n strobes (n%4)+1 times so bits are told apart
  task automatic t_codes();
    int c;
    logic [31:0] exp_cnt;
    sel2 = 10'h0a4;
    for (int g = 0; g < 5; g++)
    begin
      pulse_init();
      chan_sel = {5'(4*g+4), 5'(4*g+3), 5'(4*g+2), 5'(4*g+1)};
      open_normal();
      for (int k = 0; k < 4; k++)
      begin
        for (int n = 0; n < perf_pkg::NUM_EVT; n++)
          cpu_event[n] = (k < (n % 4) + 1);
        tick();
      end
      cpu_event = '0;
      close_window();
      for (int i = 0; i < 4; i++)
      begin
        c = 4*g + i + 1;
        exp_cnt = (c >= 20) ? 32'h0 : 32'(((c % 4) + 1) * ((c == 2) ? 2 : 1));
        `CHK("count by code", exp_cnt, cnt(i))
      end
      `CHK("absent memory stalls", 64'h0, count2)
    end
    $display("t_codes done");
  endtask

  // both ranged orders and the spare code 11, which acts as hit2 to hit1;
  // the end hit seen first while armed must not open the window
  task automatic t_range();
    for (int m = 1; m < 4; m++)
    begin
      pulse_init();
      chan_sel = {15'h0000, 5'h01};
      range_mode = 2'(m);
      prog_run = 1'h1;
      cpu_event = 20'h0_0002;
      tick();
      {brk_hit2, brk_hit1} = (m == 1) ? 2'h2 : 2'h1;
      tick();
      `CHK("end hit while armed", 1'h0, measuring)
      {brk_hit2, brk_hit1} = (m == 1) ? 2'h1 : 2'h2;
      tick();
      `CHK("start hit", 1'h1, measuring)
      {brk_hit2, brk_hit1} = 2'h0;
      repeat (5) tick();
      {brk_hit2, brk_hit1} = (m == 1) ? 2'h2 : 2'h1;
      cpu_event = '0;
      tick();
      `CHK("end hit", 1'h0, measuring)
      `CHK("ranged count", 32'h0000_0005, cnt(0))
      `CHK("disabled channel", 32'h0000_0000, cnt(1))
      {brk_hit2, brk_hit1} = 2'h0;
      prog_run = 1'h0;
      repeat (2) tick();
    end
    $display("t_range done");
  endtask

  // an init in the same cycle as an event wins, counting then resumes from zero
  task automatic t_init();
    pulse_init();
    chan_sel = {10'h000, 5'h01, 5'h02};
    open_normal();
    cpu_event = 20'h0_0006;
    repeat (2) tick();
    `CHK("branch step", 32'h0000_0004, cnt(0))
    init_req = 1'h1;
    tick();
    `CHK("init beats event", 64'h0, count_value[63:0])
    init_req = 1'h0;
    tick();
    `CHK("count after init", 32'h0000_0002, cnt(0))
    cpu_event = '0;
    close_window();
    $display("t_init done");
  endtask

  // halting the clock mid-window freezes the count even with the event held high
  task automatic t_sleep();
    pulse_init();
    chan_sel = {15'h0000, 5'h01};
    open_normal();
    cpu_event = 20'h0_0002;
    repeat (2) tick();
    clk_run = 1'h0;
    #400;
    `CHK("frozen in sleep", 32'h0000_0002, cnt(0))
    clk_run = 1'h1;
    tick();
    `CHK("resumes with clock", 32'h0000_0003, cnt(0))
    cpu_event = '0;
    close_window();
    $display("t_sleep done");
  endtask

  task automatic t_flags();
    pulse_init();
    chan_sel = {15'h0000, 5'h01};
    cache_on = 1'h1;
    open_normal();
    tick();
    `CHK("no skew on cycle event", 1'h0, cache_skew)
    chan_sel = {15'h0000, 5'h06};
    repeat (2) tick();
    `CHK("skew flagged", 1'h1, cache_skew)
    cache_on = 1'h0;
    trace_port_nonrt = 1'h1;
    cpu_event = 20'h0_0040;
    repeat (2) tick();
    `CHK("suspect flagged", 1'h1, result_suspect)
    `CHK("counting goes on", 32'h0000_0002, cnt(0))
    trace_port_nonrt = 1'h0;
    cpu_event = '0;
    close_window();
    `CHK("flags are sticky", 2'h3, {result_suspect, cache_skew})
    pulse_init();
    `CHK("flags cleared", 2'h0, {result_suspect, cache_skew})
    `CHK("no wrap seen", 4'h0, overflow)
    $display("t_flags done");
  endtask

  // ********************************************
  // main sequence and watchdog
  // ********************************************
  initial
  begin
    sys_clk = 1'h0;
    clk_run = 1'h1;
    rst_n = 1'h0;
    chan_sel = '0;
    sel2 = '0;
    range_mode = 2'h0;
    {prog_run, brk_hit1, brk_hit2, init_req, cache_on, trace_port_nonrt} = 6'h00;
    cpu_event = '0;
    error_cnt = 0;
    num_checks = 0;
    t_reset();
    t_codes();
    t_range();
    t_init();
    t_sleep();
    t_flags();
    give_verdict();
  end

  // a run far beyond the scenarios' length counts as a hang
  initial
  begin
    #1_000_000;
    error_cnt++;
    give_verdict();
  end
endmodule
